// *** rtl/urs_map.vh ***
`ifndef URS_MAP_VH
`define URS_MAP_VH
// Pin-function select field and polarity bit
`define URS_PINSEL_MSB 2
`define URS_PINSEL_LSB 0
`define URS_PINSEL_RS485 3'h3
`define URS_POL_BIT 3
// Line-control mode field and half-duplex bit
`define URS_MODE_MSB 2
`define URS_MODE_LSB 0
`define URS_MODE_MD_TX 3'h3
`define URS_MODE_MD_GATE 3'h4
`define URS_HDX_BIT 3
// Reset values
`define URS_DELAY_RST 4'h0
`define URS_CNT_RST 16'h0000
// Frame and FIFO shape
`define URS_FIFO_W 8
`define URS_FIFO_D 32
`define URS_FIFO_AW 5
`define URS_DBITS 9
`endif

// *** rtl/urs_top.v ***
// Operation
// - Pin-select value 3 turns the shared pin into transceiver direction output.
// - Direction output asserts before the first start bit is shifted.
// - With zero delay, direction releases right after the last stop bit.
// - Direction active level follows polarity bit 3.
// - Turn-around delay holds direction 1 to 15 bit times after last stop.
// - Mode values 3 and 4 select the two multidrop matching modes.
// - Multidrop compares against unicast and multicast match values.
// - Ninth bit one marks an address byte; match on either value.
// - Matched address byte is dropped, following data bytes are stored.
// - Unmatched address byte disables receiver until next match.
// - Mode 3 keeps transmitter enabled regardless of match.
// - Mode 4 enables transmitter only while a match holds.
// - Half-duplex bit 3 discards receive input while transmitting.
// - Wide 9-bit mode stores ninth bit in bit 0 of second byte.
`include "urs_map.vh"
`default_nettype none

module urs_fifo #(
  parameter W = 8,
  parameter D = 32,
  parameter AW = 5
) (
  input wire clk,
  input wire reset,
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem_reg [0:D-1];
  reg [AW-1:0] wr_reg;
  reg [AW-1:0] rd_reg;
  // Fill count spans 0 to D
  reg [AW:0] cnt_reg;
  wire push;
  wire pop;

  // Full at depth, empty at zero; count is one bit wider than the pointers
  assign in_ready = (cnt_reg != D);
  assign out_valid = (cnt_reg != 0);
  // Show-ahead read: head word always on the output
  assign out_data = mem_reg[rd_reg];
  // Only handshaken words move
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Storage write
  always @(posedge clk) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data;
    end
  end

  // Pointers and fill count
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_reg <= {AW{1'b0}};
      rd_reg <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_reg <= wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= rd_reg + 1'b1;
      end
      if (push & ~pop) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (pop & ~push) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end
endmodule

module urs_top (
  input wire clk,
  input wire reset,
  input wire [3:0] pin_mode,
  input wire [3:0] line_mode,
  input wire [3:0] turnaround_delay,
  input wire wide_mode,
  input wire nine_bit,
  input wire [7:0] unicast_match,
  input wire [7:0] multicast_match,
  input wire [15:0] baud_div,
  input wire gpio_out,
  input wire tx_valid,
  output wire tx_ready,
  input wire [8:0] tx_data,
  output reg tx_line,
  input wire rx_line,
  output wire rx_valid,
  input wire rx_ready,
  output wire [7:0] rx_data,
  output reg direction_enable_pin,
  output wire tx_enabled,
  output wire rx_enabled,
  output wire rx_overrun
);
  localparam TX_IDLE = 2'h0;
  localparam TX_SHIFT = 2'h1;
  localparam TX_HOLD = 2'h2;
  localparam RX_IDLE = 2'h0;
  localparam RX_SHIFT = 2'h1;
  localparam RX_PUSH2 = 2'h2;

  wire rs485_on;
  wire md_mode;
  wire hdx_on;
  wire dir_active;
  // Transmit state
  reg [1:0] tx_state_reg;
  reg [15:0] tx_baud_reg;
  reg [3:0] tx_bit_reg;
  reg [10:0] tx_sh_reg;
  reg [3:0] tx_delay_reg;
  // Receive state
  reg [1:0] rx_state_reg;
  reg [15:0] rx_baud_reg;
  reg [3:0] rx_bit_reg;
  reg [8:0] rx_sh_reg;
  reg match_reg;
  reg rx_meta_reg;
  reg rx_sync_reg;
  reg ovr_reg;
  // Receive FIFO feed
  reg fifo_valid;
  reg [7:0] fifo_data;
  wire fifo_ready;
  // Decoded strobes and words
  wire tx_tick;
  wire rx_tick;
  wire [3:0] nbits;
  wire [8:0] rx_word;
  wire is_addr;
  wire addr_hit;
  wire tx_shifting;
  wire tx_holding;
  wire tx_last_bit;
  wire rx_blanked;

  // Mode decode
  assign rs485_on = (pin_mode[`URS_PINSEL_MSB:`URS_PINSEL_LSB] == `URS_PINSEL_RS485);
  assign md_mode = (line_mode[`URS_MODE_MSB:`URS_MODE_LSB] == `URS_MODE_MD_TX) |
                   (line_mode[`URS_MODE_MSB:`URS_MODE_LSB] == `URS_MODE_MD_GATE);
  assign hdx_on = line_mode[`URS_HDX_BIT];

  // Transmit gating by mode
  assign tx_enabled = (line_mode[`URS_MODE_MSB:`URS_MODE_LSB] == `URS_MODE_MD_GATE) ?
                      match_reg : 1'b1;
  assign rx_enabled = ~md_mode | match_reg;
  assign rx_overrun = ovr_reg;
  assign tx_ready = (tx_state_reg != TX_SHIFT) & tx_enabled;
  assign nbits = nine_bit ? 4'ha : 4'h9;
  assign tx_tick = (tx_baud_reg == 16'h0000);
  assign rx_tick = (rx_baud_reg == 16'h0000);

  // Transmit phase decode
  assign tx_shifting = (tx_state_reg == TX_SHIFT);
  assign tx_holding = (tx_state_reg == TX_HOLD);
  // Final stop bit of the frame leaves the shifter
  assign tx_last_bit = (tx_bit_reg == nbits + 4'h1);
  // Own frame on the wire blanks the receiver in half-duplex
  assign rx_blanked = hdx_on & tx_shifting;

  // Transmitter: frame shifter and turn-around hold
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      tx_state_reg <= TX_IDLE;
      tx_baud_reg <= `URS_CNT_RST;
      tx_bit_reg <= 4'h0;
      tx_sh_reg <= 11'h7ff;
      tx_delay_reg <= `URS_DELAY_RST;
      tx_line <= 1'b1;
    end else begin
      case (tx_state_reg)
        TX_IDLE, TX_HOLD: begin
          tx_line <= 1'b1;
          if (tx_valid & tx_enabled) begin
            // Start bit waits one bit time behind direction turn-on
            tx_sh_reg <= nine_bit ? {1'b1, tx_data, 1'b0} : {2'b11, tx_data[7:0], 1'b0};
            tx_bit_reg <= 4'h0;
            tx_baud_reg <= baud_div;
            tx_state_reg <= TX_SHIFT;
          end else if (tx_state_reg == TX_HOLD) begin
            // Hold counts whole bit times before release
            if (tx_delay_reg == 4'h0) begin
              tx_state_reg <= TX_IDLE;
            end else if (tx_tick) begin
              tx_baud_reg <= baud_div;
              tx_delay_reg <= tx_delay_reg - 4'h1;
            end else begin
              tx_baud_reg <= tx_baud_reg - 16'h0001;
            end
          end
        end
        TX_SHIFT: begin
          // One bit per tick, stop bit last
          if (tx_tick) begin
            tx_baud_reg <= baud_div;
            tx_line <= tx_sh_reg[0];
            tx_sh_reg <= {1'b1, tx_sh_reg[10:1]};
            tx_bit_reg <= tx_bit_reg + 4'h1;
            if (tx_last_bit) begin
              tx_delay_reg <= turnaround_delay;
              tx_state_reg <= TX_HOLD;
            end
          end else begin
            tx_baud_reg <= tx_baud_reg - 16'h0001;
          end
        end
        default: begin
          tx_state_reg <= TX_IDLE;
        end
      endcase
    end
  end


  // Direction pin with polarity and ordinary function fallback
  assign dir_active = tx_shifting | (tx_holding & (tx_delay_reg != 4'h0));
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      direction_enable_pin <= 1'b0;
    end else if (rs485_on) begin
      // Polarity bit picks the active level
      direction_enable_pin <= dir_active ^ ~pin_mode[`URS_POL_BIT];
    end else begin
      direction_enable_pin <= gpio_out;
    end
  end


  // Receive pin synchroniser; only the second flop is read
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
    end else begin
      rx_meta_reg <= rx_line;
      rx_sync_reg <= rx_meta_reg;
    end
  end


  // Received word and address compare
  assign rx_word = nine_bit ? rx_sh_reg : {1'b0, rx_sh_reg[8:1]};
  assign is_addr = rx_word[8];
  assign addr_hit = (rx_word[7:0] == unicast_match) | (rx_word[7:0] == multicast_match);


  // Receiver: sampling, address filter, FIFO push
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      rx_state_reg <= RX_IDLE;
      rx_baud_reg <= `URS_CNT_RST;
      rx_bit_reg <= 4'h0;
      rx_sh_reg <= 9'h000;
      match_reg <= 1'b0;
      ovr_reg <= 1'b0;
      fifo_valid <= 1'b0;
      fifo_data <= 8'h00;
    end else begin
      fifo_valid <= 1'b0;
      case (rx_state_reg)
        RX_IDLE: begin
          // Ignore line while sending in half-duplex
          if (~rx_sync_reg & ~rx_blanked) begin
            rx_baud_reg <= {1'b0, baud_div[15:1]};
            rx_bit_reg <= 4'h0;
            rx_state_reg <= RX_SHIFT;
          end
        end
        RX_SHIFT: begin
          if (rx_blanked) begin
            rx_state_reg <= RX_IDLE;
          end else if (rx_tick) begin
            rx_baud_reg <= baud_div;
            rx_bit_reg <= rx_bit_reg + 4'h1;
            // Start bit checked at its middle; a high line was a glitch
            if (rx_bit_reg == 4'h0) begin
              if (rx_sync_reg) begin
                rx_state_reg <= RX_IDLE;
              end
            end else if (rx_bit_reg <= nbits - 4'h1) begin
              rx_sh_reg <= {rx_sync_reg, rx_sh_reg[8:1]};
            end else begin
              rx_state_reg <= RX_IDLE;
              // Address bytes steer the match, data bytes follow it
              if (md_mode & is_addr) begin
                match_reg <= addr_hit;
              end else if (~md_mode | match_reg) begin
                fifo_valid <= 1'b1;
                fifo_data <= rx_word[7:0];
                ovr_reg <= ovr_reg | ~fifo_ready;
                if (wide_mode & nine_bit) begin
                  rx_state_reg <= RX_PUSH2;
                end
              end
            end
          end else begin
            rx_baud_reg <= rx_baud_reg - 16'h0001;
          end
        end
        RX_PUSH2: begin
          // Second byte carries ninth bit in bit 0
          fifo_valid <= 1'b1;
          fifo_data <= {7'h00, rx_word[8]};
          ovr_reg <= ovr_reg | ~fifo_ready;
          rx_state_reg <= RX_IDLE;
        end
        default: begin
          rx_state_reg <= RX_IDLE;
        end
      endcase
    end
  end


  // Receive buffer toward the host side
  urs_fifo #(
    .W(`URS_FIFO_W),
    .D(`URS_FIFO_D),
    .AW(`URS_FIFO_AW)
  ) u_rx_fifo (
    .clk(clk),
    .reset(reset),
    .in_valid(fifo_valid),
    .in_ready(fifo_ready),
    .in_data(fifo_data),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data(rx_data)
  );
endmodule
`default_nettype wire

// *** tb/urs_node.sv ***
`default_nettype none
module urs_node #(
  parameter int B = 4
) (
  input wire logic clk,
  input wire logic tx_line,
  output logic rx_line
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [8:0] got;
  // Pulled-up line rests high
  initial rx_line = 1'b1;
  // Frame out: start, nine bits LSB first, stop
  task automatic send(input logic [8:0] v);
    logic [10:0] f;
    f = {1'b1, v, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rx_line <= f[i];
      repeat (B) @(posedge clk);
    end
  endtask
  // Frame in: sample mid-bit
  always begin
    @(negedge tx_line);
    repeat (B / 2) @(posedge clk);
    for (int i = 0; i < 9; i++) begin
      repeat (B) @(posedge clk);
      got[i] = tx_line;
    end
  end
endmodule
`default_nettype wire

// *** tb/urs_monitor.sv ***
`default_nettype none
module urs_monitor (
  input wire logic clk,
  input wire logic reset,
  input wire logic [3:0] pin_mode,
  input wire logic [3:0] line_mode,
  input wire logic gpio_out,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic tx_line,
  input wire logic direction_enable_pin,
  input wire logic tx_enabled
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);
  // Direction selected and at its active level
  wire logic sel = pin_mode[2:0] == 3'h3;
  wire logic act = direction_enable_pin == pin_mode[3];
  a_dir_lead: assert property (sel && tx_valid && tx_ready |=> ##1 act [*8])
    else $error("direction late");
  a_start_gap: assert property (tx_valid && tx_ready |=> tx_line [*3])
    else $error("start bit misplaced");
  a_dir_shift: assert property (sel && !tx_line |-> act)
    else $error("direction idle while shifting");
  a_busy_refuse: assert property (!tx_line |-> !tx_ready)
    else $error("char taken while shifting");
  a_pin_plain: assert property (!$past(sel) |-> direction_enable_pin == $past(gpio_out))
    else $error("pin lost plain function");
  a_release_high: assert property (sel && $past(act) && !act |-> tx_line)
    else $error("release before stop");
  a_mode3_on: assert property (line_mode[2:0] == 3'h3 |-> tx_enabled)
    else $error("transmitter off in mode 3");
  a_mode4_gate: assert property (line_mode[2:0] == 3'h4 && !tx_enabled |-> !tx_ready)
    else $error("transmitter open without match");
  c_take: cover property (sel && tx_valid && tx_ready);
  c_gate: cover property (line_mode[2:0] == 3'h4 && !tx_enabled);
  c_release: cover property (sel && $past(act) && !act);
endmodule
bind urs_top urs_monitor u_mon (.clk(clk), .reset(reset), .pin_mode(pin_mode),
  .line_mode(line_mode), .gpio_out(gpio_out), .tx_valid(tx_valid), .tx_ready(tx_ready),
  .tx_line(tx_line), .direction_enable_pin(direction_enable_pin), .tx_enabled(tx_enabled));
`default_nettype wire

// *** tb/uart_rs485_multidrop_control_bench.sv ***
`default_nettype none
module uart_rs485_multidrop_control_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int B = 4;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] pin_mode = 4'h0, line_mode = 4'h0, turnaround_delay = 4'h0;
  logic wide_mode = 1'b0, gpio_out = 1'b0, tx_valid = 1'b0, rx_ready = 1'b0;
  logic [8:0] tx_data = 9'h000;
  logic nine_bit = 1'b1;
  logic [7:0] unicast_match = 8'h5a, multicast_match = 8'ha5;
  logic [15:0] baud_div = 16'h0003;
  logic tx_ready, tx_line, rx_line, rx_valid, direction_enable_pin;
  logic tx_enabled, rx_enabled, rx_overrun;
  logic [7:0] rx_data;
  int err_total = 0;
  int checked = 0;
  always #5 clk = ~clk;
  urs_top dut (.clk(clk), .reset(reset), .pin_mode(pin_mode), .line_mode(line_mode),
    .turnaround_delay(turnaround_delay), .wide_mode(wide_mode), .nine_bit(nine_bit),
    .unicast_match(unicast_match), .multicast_match(multicast_match), .baud_div(baud_div),
    .gpio_out(gpio_out),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .tx_line(tx_line),
    .rx_line(rx_line), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
    .direction_enable_pin(direction_enable_pin), .tx_enabled(tx_enabled),
    .rx_enabled(rx_enabled), .rx_overrun(rx_overrun));
  urs_node #(.B(B)) node (.clk(clk), .tx_line(tx_line), .rx_line(rx_line));
  task automatic cmp(input string n, input logic [8:0] s, input logic [8:0] e);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic complete_run;
    $display("checked %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Bounded wait for a set flag
  task automatic await(ref logic f);
    for (int k = 0; f !== 1'b1; k++) begin
      @(posedge clk);
      if (k == 600) begin
        err_total++;
        complete_run;
      end
    end
  endtask
  // Pop the FIFO and compare in order, then expect it empty
  task automatic drain(input logic [7:0] e[$]);
    rx_ready <= 1'b1;
    foreach (e[i]) begin
      @(posedge clk);
      await(rx_valid);
      cmp("rx_data", rx_data, e[i]);
    end
    rx_ready <= 1'b0;
    repeat (2) @(posedge clk);
    cmp("rx_valid", rx_valid, 0);
  endtask
  // One char out, direction active time and wire bits judged
  task automatic t_tx(input logic pol, input logic [3:0] d, input logic [8:0] v);
    int n;
    int x;
    n = 0;
    // One bit of lead before the start bit, eleven frame bits, then the delay
    x = 12 * B + d * B;
    pin_mode <= {pol, 3'h3};
    turnaround_delay <= d;
    @(posedge clk);
    tx_valid <= 1'b1;
    tx_data <= v;
    @(posedge clk);
    await(tx_ready);
    tx_valid <= 1'b0;
    for (int i = 0; i < 400 && !(n > 0 && direction_enable_pin !== pol); i++) begin
      @(posedge clk);
      n += (direction_enable_pin === pol);
    end
    cmp("dir_time", n >= x && n <= x + 2, 1);
    cmp("tx_bits", node.got, v);
    $display("tx test done");
  endtask
  // Address filtering in one multidrop mode
  task automatic t_md(input logic [3:0] m);
    line_mode <= m;
    node.send(9'h15a);
    node.send(9'h011);
    node.send(9'h133);
    node.send(9'h022);
    cmp("rx_enabled", rx_enabled, 0);
    cmp("tx_enabled", tx_enabled, m == 4'h3);
    node.send(9'h1a5);
    node.send(9'h044);
    cmp("tx_enabled", tx_enabled, 1);
    drain({8'h11, 8'h44});
    $display("multidrop test done");
  endtask
  initial begin
    logic [7:0] e[$];
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    t_tx(1'b1, 4'h0, 9'h1a5);
    t_tx(1'b0, 4'h1, 9'h05a);
    t_tx(1'b1, 4'hf, 9'h133);
    pin_mode <= 4'h0;
    gpio_out <= 1'b1;
    repeat (2) @(posedge clk);
    cmp("pin", direction_enable_pin, 1);
    t_md(4'h3);
    t_md(4'h4);
    // Half duplex: receive during own transmit is dropped
    line_mode <= 4'h8;
    tx_valid <= 1'b1;
    @(posedge clk);
    await(tx_ready);
    tx_valid <= 1'b0;
    repeat (2) @(posedge clk);
    node.send(9'h077);
    repeat (3 * B) @(posedge clk);
    line_mode <= 4'h0;
    node.send(9'h066);
    drain({8'h66});
    // Wide mode fill past 32 entries with reader stalled
    wide_mode <= 1'b1;
    for (int i = 0; i < 17; i++) begin
      node.send({i[0], 8'(i * 9)});
      if (i < 16) e.push_back(8'(i * 9));
      if (i < 16) e.push_back({7'h00, i[0]});
    end
    // Last push lands after the stop bit starts
    repeat (4) @(posedge clk);
    cmp("rx_overrun", rx_overrun, 1);
    drain(e);
    $display("buffer test done");
    complete_run;
  end
endmodule
`default_nettype wire
